// >>> inc/bpd_pkg.sv
package bpd_pkg;
  typedef enum logic [1:0] {
    MODE_SINGLE   = 2'h0,
    MODE_FULL_FWD = 2'h1,
    MODE_HALF     = 2'h2,
    MODE_FULL_REV = 2'h3
  } bpd_mode_t;

  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_DIR  = 4'h2,
    ST_SHUT = 4'h4,
    ST_WAIT = 4'h8
  } bpd_state_t;

  typedef struct packed {
    logic a;
    logic b;
    logic c;
    logic d;
  } bpd_bridge_t;

  typedef struct packed {
    logic       auto_restart_enable;
    logic [6:0] count;
  } bpd_deadband_t;
endpackage : bpd_pkg

// >>> inc/bpd_regs.svh
`ifndef BPD_REGS_SVH
`define BPD_REGS_SVH
// Operation
// - Half-bridge dead band is four clocks per count.
// - Direction bit may be written any time.
// - Unmodulated outputs swap at next prescaler tick.
// - Modulated outputs inactive during direction change.
// - Auto restart only when restart bit set.
// - Restart on: flag follows the shutdown cause.
// - Restart off: flag holds until software clears.
// - Output resumes only at next period start.
// - Flag writes ignored while cause is active.
// - Comparator cause is a level, blocks clearing.
// - Writing one to flag forces shutdown.

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define BPD_OFF_CTRL        8'h00
`define BPD_OFF_TIMER       8'h04
`define BPD_OFF_DUTY        8'h08
`define BPD_OFF_DEADBAND    8'h0C
`define BPD_OFF_SHUTDOWN    8'h10
`define BPD_OFF_INT_STAT    8'h14
`define BPD_OFF_INT_MASK    8'h18

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define BPD_CTRL_MODE_LSB   6
`define BPD_TMR_PRESC_LSB   8
`define BPD_SD_FLAG_BIT     0
`define BPD_SD_SRC_PIN_BIT  1
`define BPD_SD_SRC_CMP_BIT  2
`define BPD_SD_CAUSE_BIT    3
`define BPD_EV_SHUTDOWN     0
`define BPD_EV_PERIOD       1
`define BPD_EV_DIR          2
`define BPD_EV_W            3
`define BPD_RST_PERIOD      8'hFF
`define BPD_RST_DUTY        8'h80

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BPD_TOSC_NS         100
`define BPD_PCLK_NS         100
`define BPD_DB_UNIT_TOSC    4
`define BPD_DB_UNIT_CYC     ((`BPD_DB_UNIT_TOSC * `BPD_TOSC_NS + `BPD_PCLK_NS - 1) / `BPD_PCLK_NS)
`define BPD_TICK0_TOSC      4
`define BPD_TICK1_TOSC      16
`define BPD_TICK2_TOSC      64
`define BPD_TICK0_CYC       ((`BPD_TICK0_TOSC * `BPD_TOSC_NS) / `BPD_PCLK_NS)
`define BPD_TICK1_CYC       ((`BPD_TICK1_TOSC * `BPD_TOSC_NS) / `BPD_PCLK_NS)
`define BPD_TICK2_CYC       ((`BPD_TICK2_TOSC * `BPD_TOSC_NS) / `BPD_PCLK_NS)
`endif

// >>> rtl/bpd_bridge_pwm.sv
`include "bpd_regs.svh"
module bpd_bridge_pwm (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Shutdown causes
  input  wire logic        shutdown_pin_in,
  input  wire logic        comparator_in,
  // Bridge outputs
  output logic             bridge_out_a,
  output logic             bridge_out_b,
  output logic             bridge_out_c,
  output logic             bridge_out_d,
  // Interrupt
  output logic             irq
);
  // ----------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------
  bpd_pkg::bpd_mode_t     mode_q, mode_d;
  logic [7:0]             period_q, period_d;
  logic [1:0]             presc_q, presc_d;
  logic [7:0]             duty_q, duty_d;
  bpd_pkg::bpd_deadband_t db_q, db_d;
  logic                   src_pin_q, src_pin_d;
  logic                   src_cmp_q, src_cmp_d;
  logic [`BPD_EV_W-1:0]   mask_q, mask_d;
  logic [`BPD_EV_W-1:0]   stat_q, stat_d;
  logic [31:0]            prdata_q, prdata_d;
  logic                   pslverr_q, pslverr_d;

  // ----------------------------------------------------------------
  // Output stage state
  // ----------------------------------------------------------------
  bpd_pkg::bpd_state_t    state_q, state_d;
  bpd_pkg::bpd_mode_t     mode_eff_q, mode_eff_d;
  bpd_pkg::bpd_bridge_t   out_q, out_d;
  logic                   flag_q, flag_d;
  logic                   cause_q;

  logic                   setup;
  logic                   wr;
  logic                   rd;
  logic                   mapped;
  logic                   cause;
  logic                   dir_change;
  logic [`BPD_EV_W-1:0]   ev;
  logic [7:0]             tmr_count;
  logic                   tmr_tick;
  logic                   tmr_wrap;
  logic                   pwm;
  logic                   db_a;
  logic                   db_b;
  logic [6:0]             db_count;

  bpd_period_timer #(
    .W (8)
  ) u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .period  (period_q),
    .presc   (presc_q),
    .count   (tmr_count),
    .tick    (tmr_tick),
    .wrap    (tmr_wrap)
  );

  assign pwm      = (tmr_count < duty_q);
  assign db_count = (mode_eff_q == bpd_pkg::MODE_HALF) ? db_q.count : 7'h00;

  bpd_deadband #(
    .CW   (7),
    .UNIT (`BPD_DB_UNIT_CYC)
  ) u_db_a (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (pwm),
    .count   (db_count),
    .sig_out (db_a)
  );

  bpd_deadband #(
    .CW   (7),
    .UNIT (`BPD_DB_UNIT_CYC)
  ) u_db_b (
    .pclk    (pclk),
    .presetn (presetn),
    .sig_in  (!pwm),
    .count   (db_count),
    .sig_out (db_b)
  );

  // ----------------------------------------------------------------
  // APB decode and register file
  // ----------------------------------------------------------------
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite && !pslverr_q;
  assign rd     = psel && penable && !pwrite && !pslverr_q;
  assign cause  = (src_pin_q && shutdown_pin_in) || (src_cmp_q && comparator_in);

  // Read data is captured in the setup cycle so that pready can stay high.
  always_comb begin
    mode_d    = mode_q;
    period_d  = period_q;
    presc_d   = presc_q;
    duty_d    = duty_q;
    db_d      = db_q;
    src_pin_d = src_pin_q;
    src_cmp_d = src_cmp_q;
    mask_d    = mask_q;
    prdata_d  = prdata_q;
    pslverr_d = pslverr_q;
    mapped    = 1'b1;
    if (setup) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        `BPD_OFF_CTRL:     prdata_d[`BPD_CTRL_MODE_LSB +: 2] = mode_q;
        `BPD_OFF_TIMER:    prdata_d[9:0] = {presc_q, period_q};
        `BPD_OFF_DUTY:     prdata_d[7:0] = duty_q;
        `BPD_OFF_DEADBAND: prdata_d[7:0] = db_q;
        `BPD_OFF_SHUTDOWN: prdata_d[3:0] = {cause, src_cmp_q, src_pin_q, flag_q};
        `BPD_OFF_INT_STAT: prdata_d[`BPD_EV_W-1:0] = stat_q;
        `BPD_OFF_INT_MASK: prdata_d[`BPD_EV_W-1:0] = mask_q;
        default:           mapped = 1'b0;
      endcase
      pslverr_d = !mapped;
    end
    if (wr) begin
      case (paddr)
        `BPD_OFF_CTRL: begin
          mode_d = bpd_pkg::bpd_mode_t'(pwdata[`BPD_CTRL_MODE_LSB +: 2]);
        end
        `BPD_OFF_TIMER: begin
          period_d = pwdata[7:0];
          presc_d  = pwdata[`BPD_TMR_PRESC_LSB +: 2];
        end
        `BPD_OFF_DUTY: begin
          duty_d = pwdata[7:0];
        end
        `BPD_OFF_DEADBAND: begin
          db_d = pwdata[7:0];
        end
        `BPD_OFF_SHUTDOWN: begin
          src_pin_d = pwdata[`BPD_SD_SRC_PIN_BIT];
          src_cmp_d = pwdata[`BPD_SD_SRC_CMP_BIT];
        end
        `BPD_OFF_INT_MASK: begin
          mask_d = pwdata[`BPD_EV_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Only the bits that were returned are cleared, so a new event is kept.
    stat_d = stat_q;
    if (rd && (paddr == `BPD_OFF_INT_STAT)) begin
      stat_d = stat_q & ~prdata_q[`BPD_EV_W-1:0];
    end
    stat_d = stat_d | ev;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q    <= bpd_pkg::MODE_SINGLE;
      period_q  <= `BPD_RST_PERIOD;
      presc_q   <= 2'h0;
      duty_q    <= `BPD_RST_DUTY;
      db_q      <= '0;
      src_pin_q <= 1'b0;
      src_cmp_q <= 1'b0;
      mask_q    <= '0;
      stat_q    <= '0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      period_q  <= period_d;
      presc_q   <= presc_d;
      duty_q    <= duty_d;
      db_q      <= db_d;
      src_pin_q <= src_pin_d;
      src_cmp_q <= src_cmp_d;
      mask_q    <= mask_d;
      stat_q    <= stat_d;
      prdata_q  <= prdata_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Shutdown flag, direction change and output steering
  // ----------------------------------------------------------------
  assign dir_change = ((mode_q == bpd_pkg::MODE_FULL_FWD) && (mode_eff_q == bpd_pkg::MODE_FULL_REV)) ||
                      ((mode_q == bpd_pkg::MODE_FULL_REV) && (mode_eff_q == bpd_pkg::MODE_FULL_FWD));

  always_comb begin
    // A forced shutdown written in the cycle the cause goes away must not be lost, so the write comes after the auto-restart clear.
    flag_d = flag_q;
    if (db_q.auto_restart_enable && cause_q && !cause) begin
      flag_d = 1'b0;
    end
    if (wr && (paddr == `BPD_OFF_SHUTDOWN) && !cause) begin
      flag_d = pwdata[`BPD_SD_FLAG_BIT];
    end
    if (cause) begin
      flag_d = 1'b1;
    end

    state_d    = state_q;
    mode_eff_d = mode_eff_q;
    case (state_q)
      bpd_pkg::ST_RUN: begin
        if (dir_change) begin
          state_d = bpd_pkg::ST_DIR;
        end else begin
          mode_eff_d = mode_q;
        end
      end
      bpd_pkg::ST_DIR: begin
        if (tmr_tick) begin
          mode_eff_d = mode_q;
        end
        if (tmr_wrap) begin
          state_d = bpd_pkg::ST_RUN;
        end
      end
      bpd_pkg::ST_SHUT: begin
        if (!flag_q) begin
          state_d = bpd_pkg::ST_WAIT;
        end
      end
      bpd_pkg::ST_WAIT: begin
        if (tmr_wrap) begin
          state_d    = bpd_pkg::ST_RUN;
          mode_eff_d = mode_q;
        end
      end
      default: begin
        state_d = bpd_pkg::ST_SHUT;
      end
    endcase
    if (flag_q) begin
      state_d = bpd_pkg::ST_SHUT;
    end

    out_d = '0;
    case (mode_eff_q)
      bpd_pkg::MODE_SINGLE: begin
        out_d.a = pwm;
      end
      bpd_pkg::MODE_HALF: begin
        out_d.a = db_a;
        out_d.b = db_b;
      end
      bpd_pkg::MODE_FULL_FWD: begin
        out_d.a = 1'b1;
        out_d.d = pwm;
      end
      default: begin
        out_d.c = 1'b1;
        out_d.b = pwm;
      end
    endcase
    if ((state_q == bpd_pkg::ST_DIR) || (state_d == bpd_pkg::ST_DIR)) begin
      out_d.b = 1'b0;
      out_d.d = 1'b0;
    end
    if (state_q != bpd_pkg::ST_RUN && state_q != bpd_pkg::ST_DIR) begin
      out_d = '0;
    end
    if (flag_q) begin
      out_d = '0;
    end

    ev                   = '0;
    ev[`BPD_EV_SHUTDOWN] = flag_d && !flag_q;
    ev[`BPD_EV_PERIOD]   = tmr_wrap;
    ev[`BPD_EV_DIR]      = (state_q == bpd_pkg::ST_DIR) && tmr_wrap;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= bpd_pkg::ST_WAIT;
      mode_eff_q <= bpd_pkg::MODE_SINGLE;
      out_q      <= '0;
      flag_q     <= 1'b0;
      cause_q    <= 1'b0;
    end else begin
      state_q    <= state_d;
      mode_eff_q <= mode_eff_d;
      out_q      <= out_d;
      flag_q     <= flag_d;
      cause_q    <= cause;
    end
  end

  assign prdata       = prdata_q;
  assign pready       = 1'b1;
  assign pslverr      = pslverr_q && psel && penable;
  assign bridge_out_a = out_q.a;
  assign bridge_out_b = out_q.b;
  assign bridge_out_c = out_q.c;
  assign bridge_out_d = out_q.d;
  assign irq          = |(stat_q & mask_q);
endmodule : bpd_bridge_pwm

// >>> rtl/bpd_deadband.sv
`include "bpd_regs.svh"
module bpd_deadband #(
  parameter int CW   = 7,
  parameter int UNIT = `BPD_DB_UNIT_CYC
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Signal and delay
  input  wire logic          sig_in,
  input  wire logic [CW-1:0] count,
  output logic               sig_out
);
  localparam int TW = CW + $clog2(UNIT) + 1;

  logic [TW-1:0] cnt_q;
  logic [TW-1:0] cnt_d;
  logic [TW-1:0] target;
  logic          out_q;
  logic          out_d;

  // Only the rising edge is held back; the falling edge passes at once.
  always_comb begin
    target = TW'(count) * TW'(UNIT);
    cnt_d  = cnt_q;
    if (!sig_in) begin
      cnt_d = '0;
    end else if (cnt_q != target) begin
      cnt_d = cnt_q + TW'(1);
    end
    out_d = sig_in && (cnt_q == target);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      out_q <= out_d;
    end
  end

  assign sig_out = out_q;
endmodule : bpd_deadband

// >>> rtl/bpd_period_timer.sv
`include "bpd_regs.svh"
module bpd_period_timer #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Setup
  input  wire logic [W-1:0] period,
  input  wire logic [1:0]   presc,
  // Timer state
  output logic [W-1:0]      count,
  output logic              tick,
  output logic              wrap
);
  logic [6:0]   div_q;
  logic [6:0]   div_d;
  logic [6:0]   div_last;
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         tick_q;
  logic         tick_d;
  logic         wrap_q;
  logic         wrap_d;

  always_comb begin
    case (presc)
      2'h0:    div_last = 7'(`BPD_TICK0_CYC - 1);
      2'h1:    div_last = 7'(`BPD_TICK1_CYC - 1);
      default: div_last = 7'(`BPD_TICK2_CYC - 1);
    endcase
    tick_d = (div_q >= div_last);
    div_d  = tick_d ? 7'h00 : div_q + 7'h01;
    wrap_d = tick_d && (cnt_q >= period);
    cnt_d  = cnt_q;
    if (tick_d) begin
      cnt_d = wrap_d ? '0 : cnt_q + W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 7'h00;
      cnt_q  <= '0;
      tick_q <= 1'b0;
      wrap_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
      wrap_q <= wrap_d;
    end
  end

  assign count = cnt_q;
  assign tick  = tick_q;
  assign wrap  = wrap_q;
endmodule : bpd_period_timer

// >>> tb/bpd_bridge_load.sv
module bpd_bridge_load (
  // Gate drives
  input  wire logic bridge_out_a,
  input  wire logic bridge_out_b,
  input  wire logic bridge_out_c,
  input  wire logic bridge_out_d,
  // Overcurrent request from the scenario
  input  wire logic fault,
  // Fault report
  output logic      shutdown_pin_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Both switches of one leg on is a short, so the load reports it like an overcurrent.
  assign shutdown_pin_in = fault | (bridge_out_a & bridge_out_b) | (bridge_out_c & bridge_out_d);
endmodule : bpd_bridge_load

// >>> tb/bpd_bridge_pwm_props.sv
module bpd_bridge_pwm_props (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Bridge outputs
  input wire logic        bridge_out_a,
  input wire logic        bridge_out_b,
  input wire logic        bridge_out_c,
  input wire logic        bridge_out_d
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       acc;
  logic       mapped;
  logic [3:0] outs;
  assign acc    = psel && penable;
  assign mapped = (paddr[1:0] == 2'h0) && (paddr <= 8'h18);
  assign outs   = {bridge_out_a, bridge_out_b, bridge_out_c, bridge_out_d};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_idle8;
    (outs == 4'h0) [*8];
  endsequence
  sequence s_bad_access;
    (psel && !penable) ##1 (acc && !mapped && paddr[1:0] == 2'h0);
  endsequence
  a_idle_after_reset: assert property ($rose(presetn) |-> s_idle8)
    else $error("bridge driven before first period");
  a_leg_ab_apart: assert property (!(bridge_out_a && bridge_out_b))
    else $error("a and b high together");
  a_leg_cd_apart: assert property (!(bridge_out_c && bridge_out_d))
    else $error("c and d high together");
  a_diag_ac_apart: assert property (!(bridge_out_a && bridge_out_c))
    else $error("a and c high together");
  a_ready_always: assert property (pready)
    else $error("pready low");
  a_err_unmapped: assert property (s_bad_access |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_only_bad: assert property (pslverr |-> acc && !mapped)
    else $error("pslverr without unmapped access");
  a_rdata_held: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data moved outside setup");
endmodule : bpd_bridge_pwm_props

bind bpd_bridge_pwm bpd_bridge_pwm_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .bridge_out_a(bridge_out_a),
  .bridge_out_b(bridge_out_b), .bridge_out_c(bridge_out_c), .bridge_out_d(bridge_out_d)
);

// >>> tb/tb_top.sv
`include "bpd_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [7:0]           paddr;
  logic [31:0]          pwdata;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic                 shutdown_pin_in;
  logic                 comparator_in;
  logic                 fault;
  logic                 irq;
  bpd_pkg::bpd_bridge_t br;
  logic [4:0]           obs;
  logic [31:0]          rd;
  logic                 err;
  logic                 ok;
  int                   errors;
  int                   n_checks;
  int                   n;
  int                   g0;
  int                   hi;
  assign obs = {irq, br};
  always #50 pclk = ~pclk;
  bpd_bridge_pwm uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shutdown_pin_in(shutdown_pin_in), .comparator_in(comparator_in), .bridge_out_a(br.a),
    .bridge_out_b(br.b), .bridge_out_c(br.c), .bridge_out_d(br.d), .irq(irq)
  );
  bpd_bridge_load u_load (
    .bridge_out_a(br.a), .bridge_out_b(br.b), .bridge_out_c(br.c), .bridge_out_d(br.d),
    .fault(fault), .shutdown_pin_in(shutdown_pin_in)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic timeout();
    errors++;
    $display("unexpected wait: expected event seen none");
    complete_run();
  endtask : timeout

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) timeout();
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk

  task automatic wait_bit(input int idx, input logic v, output int cnt);
    for (cnt = 1; cnt < 3000; cnt++) begin
      @(posedge pclk);
      #1;
      if (obs[idx] === v) return;
    end
    timeout();
  endtask : wait_bit

  // Cycles from b falling to a rising in half-bridge mode.
  task automatic gap(output int cnt);
    wait_bit(2, 1'b1, cnt);
    wait_bit(2, 1'b0, cnt);
    wait_bit(3, 1'b1, cnt);
  endtask : gap

  // Each cause change is given time to reach the flag before the next step.
  task automatic cause(input logic pin, input logic cmp);
    @(posedge pclk);
    fault         <= pin;
    comparator_in <= cmp;
    repeat (8) @(posedge pclk);
  endtask : cause

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    comparator_in = 1'b0;
    fault = 1'b0;
    errors = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`BPD_OFF_TIMER, 32'hFF, "period reset");
    rdchk(`BPD_OFF_DUTY, 32'h80, "duty reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk("unmapped err", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
    $display("test registers finished");
    wr(`BPD_OFF_CTRL, 32'h80);
    gap(g0);
    wr(`BPD_OFF_DEADBAND, 32'h40);
    gap(n);
    chk("no dead band", 32'd1, 32'(g0));
    chk("dead band", 32'd256, 32'(n));
    $display("test half bridge finished");
    wr(`BPD_OFF_TIMER, 32'h0F);
    wr(`BPD_OFF_DUTY, 32'h08);
    for (int m = 0; m < 3; m++) begin
      wr(`BPD_OFF_CTRL, (m == 0) ? 32'h00 : ((m == 1) ? 32'h40 : 32'hC0));
      repeat (200) @(posedge pclk);
      ok = 1'b1;
      hi = 0;
      repeat (128) begin
        @(posedge pclk);
        #1;
        ok &= (m == 0) ? (br === 4'h8 || br === 4'h0) :
              (m == 1) ? (br === 4'h8 || br === 4'h9) : (br === 4'h2 || br === 4'h6);
        hi += int'((m == 0) ? br.a : ((m == 1) ? br.d : br.b));
      end
      chk("steady legs", 32'h1, 32'(ok));
      chk("modulated share", 32'd64, 32'(hi));
    end
    for (int p = 0; p < 3; p++) begin
      wr(`BPD_OFF_TIMER, 32'(32'h0F | (p << 8)));
      repeat (100) @(posedge pclk);
      wr(`BPD_OFF_CTRL, p[0] ? 32'hC0 : 32'h40);
      ok = 1'b1;
      for (n = 1; n < 200; n++) begin
        @(posedge pclk);
        #1;
        if (obs[p[0] ? 1 : 3] === 1'b1) break;
        if (n > 1) ok &= (br.b === 1'b0 && br.d === 1'b0);
      end
      chk("swap time", 32'h1, 32'(n <= (4 << (2 * p)) + 3));
      chk("modulated idle", 32'h1, 32'(ok));
    end
    apb(1'b0, `BPD_OFF_INT_STAT, 32'h0);
    chk("direction event", 32'h4, rd & 32'h4);
    $display("test full bridge finished");
    wr(`BPD_OFF_TIMER, 32'h0F);
    wr(`BPD_OFF_INT_MASK, 32'h1);
    wr(`BPD_OFF_DEADBAND, 32'h80);
    wr(`BPD_OFF_SHUTDOWN, 32'h2);
    apb(1'b0, `BPD_OFF_INT_STAT, 32'h0);
    cause(1'b1, 1'b0);
    rdchk(`BPD_OFF_SHUTDOWN, 32'hB, "pin flag");
    chk("outputs off", 32'h0, 32'(br));
    chk("irq raised", 32'h1, 32'(irq));
    wr(`BPD_OFF_SHUTDOWN, 32'h2);
    rdchk(`BPD_OFF_SHUTDOWN, 32'hB, "flag write ignored");
    cause(1'b0, 1'b0);
    rdchk(`BPD_OFF_SHUTDOWN, 32'h2, "auto clear");
    apb(1'b0, `BPD_OFF_INT_STAT, 32'h0);
    chk("status event", 32'h1, rd & 32'h1);
    repeat (2) @(posedge pclk);
    #1;
    chk("irq cleared", 32'h0, 32'(irq));
    wr(`BPD_OFF_DEADBAND, 32'h0);
    cause(1'b1, 1'b0);
    cause(1'b0, 1'b0);
    rdchk(`BPD_OFF_SHUTDOWN, 32'h3, "flag held");
    wr(`BPD_OFF_INT_MASK, 32'h2);
    repeat (2) begin
      apb(1'b0, `BPD_OFF_INT_STAT, 32'h0);
      wait_bit(4, 1'b1, n);
    end
    wr(`BPD_OFF_SHUTDOWN, 32'h2);
    wait_bit(3, 1'b1, n);
    chk("resume delay", 32'h1, 32'(n > 40 && n <= 70));
    wr(`BPD_OFF_DEADBAND, 32'h80);
    wr(`BPD_OFF_SHUTDOWN, 32'h4);
    cause(1'b0, 1'b1);
    wr(`BPD_OFF_SHUTDOWN, 32'h4);
    rdchk(`BPD_OFF_SHUTDOWN, 32'hD, "comparator flag");
    cause(1'b0, 1'b0);
    rdchk(`BPD_OFF_SHUTDOWN, 32'h4, "comparator release");
    repeat (150) @(posedge pclk);
    wr(`BPD_OFF_SHUTDOWN, 32'h1);
    repeat (20) @(posedge pclk);
    rdchk(`BPD_OFF_SHUTDOWN, 32'h1, "forced flag");
    chk("forced off", 32'h0, 32'(br));
    wr(`BPD_OFF_SHUTDOWN, 32'h0);
    rdchk(`BPD_OFF_SHUTDOWN, 32'h0, "forced clear");
    $display("test shutdown finished");
    complete_run();
  end
endmodule : tb_top
